// File: logic/guest_activity_event_blocking_state.sv
// Guest activity, interruptibility and pending-debug state holder
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// RULE1: 32-bit activity field, zero means running
// RULE2: Activity one means halted by halt
// RULE3: Activity two means shutdown after serious error
// RULE4: Activity three means waiting for startup interrupt
// RULE5: Fault during double fault delivery gives shutdown
// RULE6: Monitor-wait inactivity never shown in activity
// RULE7: Software checks capability register before use
// RULE8: Bit0 set by interrupt-flag set blocking
// RULE9: Bit1 set by stack segment load blocking
// RULE10: Bit2 shows system-management interrupts blocked
// RULE11: Bit3 NMI blocked until interrupt return
// RULE12: Clear bit3 does not mean NMI free
// RULE13: Virtual NMI mode makes bit3 guest readiness
// RULE14: Entry fails when interruptibility bits 31:4 set
// RULE15: 64-bit pending debug exceptions field kept
// RULE16: Store on exit, load on entry
// RULE17: Breakpoint hit flags set regardless of enable
// RULE18: Reset clears all three fields to zero
module guest_activity_event_blocking_state
   import guest_state_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_ce,
   // Register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // Core events, one-cycle pulses; i_interrupt_flag is a level
   input  wire logic        i_vm_exit,
   input  wire logic        i_vm_entry,
   input  wire logic        i_halt_instruction,
   input  wire logic        i_startup_interprocessor_interrupt,
   input  wire logic        i_wait_startup,
   input  wire logic        i_serious_error,
   input  wire logic        i_exception,
   input  wire logic        i_monitor_wait_instruction,
   input  wire logic        i_set_interrupt_flag_instruction,
   input  wire logic        i_interrupt_flag,
   input  wire logic        i_stack_segment_load,
   input  wire logic        i_instruction_retired,
   input  wire logic        i_system_management_interrupt,
   input  wire logic        i_rsm,
   input  wire logic        i_nmi_delivered,
   input  wire logic        i_interrupt_return_instruction,
   input  wire logic        i_double_fault_start,
   input  wire logic        i_double_fault_done,
   input  wire logic [3:0]  i_breakpoint_hit_flags,
   input  wire logic        i_enabled_breakpoint,
   input  wire logic        i_single_step,
   input  wire logic        i_debug_delivered,
   // Core state mirrors, one cycle behind the live state, and event outputs
   output logic      [31:0] o_activity,
   output logic      [31:0] o_interruptibility,
   output logic      [63:0] o_pending_debug,
   output logic             o_entry_fail,
   output logic             o_irq
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [31:0] live_act_ff;
   logic [31:0] live_intr_ff;
   logic [63:0] live_pdbg_ff;
   logic [31:0] gst_act_ff;
   logic [31:0] gst_intr_ff;
   logic [63:0] gst_pdbg_ff;
   logic        vnmi_ff;
   logic        in_df_ff;
   logic        in_vm_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic [IRQ_W-1:0] irq_set;
   logic        entry_bad;
   logic        entry_ok;
   logic        triple;
   logic        wr_act;
   logic        wr_intr;
   logic        wr_plo;
   logic        wr_phi;
   logic        wr_ctrl;
   logic        wr_mask;
   logic        rd_stat;
   logic        exit_save;

   assign entry_bad = i_vm_entry && ((gst_intr_ff & INTR_RSVD_MASK) != 32'h0000_0000); //RULE14
   assign entry_ok  = i_vm_entry && !entry_bad;
   assign triple    = in_df_ff && i_exception; //RULE5
   assign wr_act    = i_wr && (i_addr == ADDR_ACTIVITY);
   assign wr_intr   = i_wr && (i_addr == ADDR_INTR_STATE);
   assign wr_plo    = i_wr && (i_addr == ADDR_PDBG_LO);
   assign wr_phi    = i_wr && (i_addr == ADDR_PDBG_HI);
   assign wr_ctrl   = i_wr && (i_addr == ADDR_CTRL);
   assign wr_mask   = i_wr && (i_addr == ADDR_IRQ_MASK);
   assign rd_stat   = i_rd && (i_addr == ADDR_IRQ_STATUS);
   // Only an exit from a cleanly entered guest overwrites the guest fields
   assign exit_save = i_vm_exit && in_vm_ff; //RULE16

   // ----------------------------------------------------------------
   // Double fault tracking
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         in_df_ff <= 1'b0;
      else if (i_ce)
      begin
         if (i_double_fault_start)
            in_df_ff <= 1'b1;
         else if (i_double_fault_done || triple)
            in_df_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Live activity state
   // ----------------------------------------------------------------
   // Monitor-wait is ignored on purpose: that sleep is not encoded here
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         live_act_ff <= RST_ACTIVITY; //RULE18
      else if (i_ce)
      begin
         if (entry_ok)
            live_act_ff <= gst_act_ff; //RULE16
         else if (triple || i_serious_error)
            live_act_ff <= ACT_SHUTDOWN; //RULE3
         else if (i_wait_startup)
            live_act_ff <= ACT_WAIT_SIP; //RULE4
         else if (i_halt_instruction && (live_act_ff == ACT_RUNNING))
            live_act_ff <= ACT_HALTED; //RULE2
         else if (i_startup_interprocessor_interrupt && (live_act_ff == ACT_WAIT_SIP))
            live_act_ff <= ACT_RUNNING; //RULE1
         else if (i_monitor_wait_instruction)
            live_act_ff <= live_act_ff; //RULE6
      end
   end

   // ----------------------------------------------------------------
   // Live interruptibility state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         live_intr_ff <= RST_INTR;
      else if (i_ce)
      begin
         if (entry_ok)
            live_intr_ff <= gst_intr_ff;
         else
         begin
            // Shadow bits last one instruction; a new setter wins over expiry
            if (i_set_interrupt_flag_instruction && !i_interrupt_flag)
               live_intr_ff[BIT_BLK_SIF] <= 1'b1; //RULE8
            else if (i_instruction_retired)
               live_intr_ff[BIT_BLK_SIF] <= 1'b0;
            if (i_stack_segment_load)
               live_intr_ff[BIT_BLK_SSL] <= 1'b1; //RULE9
            else if (i_instruction_retired)
               live_intr_ff[BIT_BLK_SSL] <= 1'b0;
            if (i_system_management_interrupt)
               live_intr_ff[BIT_BLK_SMI] <= 1'b1; //RULE10
            else if (i_rsm)
               live_intr_ff[BIT_BLK_SMI] <= 1'b0;
            // In virtual mode the bit is guest readiness, left to software
            if (!vnmi_ff && (i_nmi_delivered || i_system_management_interrupt))
               live_intr_ff[BIT_BLK_NMI] <= 1'b1; //RULE11
            else if (!vnmi_ff && i_interrupt_return_instruction)
               live_intr_ff[BIT_BLK_NMI] <= 1'b0; //RULE13
            live_intr_ff[31:4] <= 28'h0000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Live pending debug exceptions
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         live_pdbg_ff <= RST_PDBG;
      else if (i_ce)
      begin
         if (entry_ok)
            live_pdbg_ff <= gst_pdbg_ff;
         else if (i_debug_delivered)
            live_pdbg_ff <= RST_PDBG;
         else
         begin
            live_pdbg_ff[3:0]         <= live_pdbg_ff[3:0] | i_breakpoint_hit_flags; //RULE17
            live_pdbg_ff[BIT_PDBG_EN] <= live_pdbg_ff[BIT_PDBG_EN] | i_enabled_breakpoint;
            live_pdbg_ff[BIT_PDBG_BS] <= live_pdbg_ff[BIT_PDBG_BS] | i_single_step; //RULE15
         end
      end
   end

   // ----------------------------------------------------------------
   // Guest fields: software writes, stored on exit
   // ----------------------------------------------------------------
   // A storing exit wins over a software write in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         gst_act_ff <= RST_ACTIVITY; //RULE18
      else if (i_ce)
      begin
         if (exit_save)
            gst_act_ff <= live_act_ff; //RULE16
         else if (wr_act)
            gst_act_ff <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         gst_intr_ff <= RST_INTR;
      else if (i_ce)
      begin
         if (exit_save)
            gst_intr_ff <= live_intr_ff;
         else if (wr_intr)
            gst_intr_ff <= i_wdata;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         gst_pdbg_ff <= RST_PDBG;
      else if (i_ce)
      begin
         if (exit_save)
            gst_pdbg_ff <= live_pdbg_ff;
         else
         begin
            if (wr_plo)
               gst_pdbg_ff[31:0] <= i_wdata;
            if (wr_phi)
               gst_pdbg_ff[63:32] <= i_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Virtual NMI control
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         vnmi_ff <= 1'b0;
      else if (i_ce && wr_ctrl)
         vnmi_ff <= i_wdata[BIT_CTRL_VNMI]; //RULE13
   end

   // ----------------------------------------------------------------
   // Interrupt mask
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         irq_mask_ff <= '0;
      else if (i_ce && wr_mask)
         irq_mask_ff <= i_wdata[IRQ_W-1:0];
   end

   // ----------------------------------------------------------------
   // Guest-mode tracking
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         in_vm_ff <= 1'b0;
      else if (i_ce)
      begin
         if (entry_ok)
            in_vm_ff <= 1'b1;
         else if (i_vm_exit)
            in_vm_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status: read clears, a new event wins over the clear
   // ----------------------------------------------------------------
   always_comb
   begin
      irq_set                 = '0;
      irq_set[IRQ_ENTRY_FAIL] = entry_bad;
      irq_set[IRQ_SHUTDOWN]   = triple || i_serious_error;
      irq_set[IRQ_EXIT_DONE]  = exit_save;
      irq_set[IRQ_ENTRY_DONE] = entry_ok;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         irq_stat_ff <= '0;
      else if (i_ce)
      begin
         if (rd_stat)
            irq_stat_ff <= irq_set;
         else
            irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end

   // ----------------------------------------------------------------
   // Core state mirrors, one cycle behind the live state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_activity         <= RST_ACTIVITY;
         o_interruptibility <= RST_INTR;
         o_pending_debug    <= RST_PDBG;
      end
      else if (i_ce)
      begin
         o_activity         <= live_act_ff;
         o_interruptibility <= live_intr_ff; //RULE12
         o_pending_debug    <= live_pdbg_ff;
      end
   end

   // ----------------------------------------------------------------
   // Event outputs
   // ----------------------------------------------------------------
   // New events are ORed in so the level rises one cycle after them
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_entry_fail <= 1'b0;
         o_irq        <= 1'b0;
      end
      else if (i_ce)
      begin
         o_entry_fail <= entry_bad; //RULE14
         o_irq        <= |((irq_stat_ff | irq_set) & irq_mask_ff);
      end
   end

   // ----------------------------------------------------------------
   // Read data: stands one cycle after the read strobe, zero otherwise
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_rdata <= 32'h0000_0000;
      else if (i_ce)
      begin
         o_rdata <= 32'h0000_0000;
         if (i_rd)
         begin
            unique case (i_addr)
               ADDR_ACTIVITY:   o_rdata <= gst_act_ff;
               ADDR_INTR_STATE: o_rdata <= gst_intr_ff;
               ADDR_PDBG_LO:    o_rdata <= gst_pdbg_ff[31:0];
               ADDR_PDBG_HI:    o_rdata <= gst_pdbg_ff[63:32];
               ADDR_CTRL:       o_rdata <= {31'h00000000, vnmi_ff};
               ADDR_IRQ_STATUS: o_rdata <= {28'h0000000, irq_stat_ff};
               ADDR_IRQ_MASK:   o_rdata <= {28'h0000000, irq_mask_ff};
               ADDR_CAPS:       o_rdata <= CAPS_VALUE; //RULE7
               default:         o_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : guest_activity_event_blocking_state

// File: logic/guest_state_pkg.sv
// Package of constants for the guest non-register state block
package guest_state_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses, four apart
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_ACTIVITY   = 8'h00;
   localparam logic [7:0] ADDR_INTR_STATE = 8'h04;
   localparam logic [7:0] ADDR_PDBG_LO    = 8'h08;
   localparam logic [7:0] ADDR_PDBG_HI    = 8'h0C;
   localparam logic [7:0] ADDR_CTRL       = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h18;
   localparam logic [7:0] ADDR_CAPS       = 8'h1C;

   // ----------------------------------------------------------------
   // Activity state encodings
   // ----------------------------------------------------------------
   localparam logic [31:0] ACT_RUNNING  = 32'h0000_0000;
   localparam logic [31:0] ACT_HALTED   = 32'h0000_0001;
   localparam logic [31:0] ACT_SHUTDOWN = 32'h0000_0002;
   localparam logic [31:0] ACT_WAIT_SIP = 32'h0000_0003;
   // Supported encodings, one bit per encoding
   localparam logic [31:0] CAPS_VALUE   = 32'h0000_000F;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BIT_BLK_SIF   = 0;
   localparam int BIT_BLK_SSL   = 1;
   localparam int BIT_BLK_SMI   = 2;
   localparam int BIT_BLK_NMI   = 3;
   localparam int BIT_CTRL_VNMI = 0;
   localparam int BIT_PDBG_EN   = 12;
   localparam int BIT_PDBG_BS   = 14;
   localparam logic [31:0] INTR_RSVD_MASK = 32'hFFFF_FFF0;

   // Interrupt status bits
   localparam int IRQ_ENTRY_FAIL = 0;
   localparam int IRQ_SHUTDOWN   = 1;
   localparam int IRQ_EXIT_DONE  = 2;
   localparam int IRQ_ENTRY_DONE = 3;
   localparam int IRQ_W          = 4;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_ACTIVITY = 32'h0000_0000;
   localparam logic [31:0] RST_INTR     = 32'h0000_0000;
   localparam logic [63:0] RST_PDBG     = 64'h0000_0000_0000_0000;
endpackage : guest_state_pkg

// File: verification/guest_state_sva.sv
// Port-level checker for the guest state block
`timescale 1ns/1ns
module guest_state_sva
   import guest_state_pkg::*;
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   // Inputs watched
   input wire logic        i_ce,
   input wire logic        i_rd,
   input wire logic        i_vm_entry,
   input wire logic        i_halt_instruction,
   input wire logic        i_wait_startup,
   input wire logic        i_serious_error,
   input wire logic        i_exception,
   input wire logic        i_set_interrupt_flag_instruction,
   input wire logic        i_interrupt_flag,
   input wire logic        i_system_management_interrupt,
   input wire logic        i_rsm,
   input wire logic [3:0]  i_breakpoint_hit_flags,
   input wire logic        i_debug_delivered,
   // Outputs watched
   input wire logic [31:0] o_rdata,
   input wire logic [31:0] o_activity,
   input wire logic [31:0] o_interruptibility,
   input wire logic [63:0] o_pending_debug,
   input wire logic        o_entry_fail,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   // ----------------------------------------------------------------
   // Activity changes need a cause two edges back (live, then output)
   // ----------------------------------------------------------------
   AST_ACT_HALT: assert property ($past(i_ce) && $past(i_ce, 2) && o_activity == ACT_HALTED
      && $past(o_activity) != ACT_HALTED |-> $past(i_halt_instruction, 2) || $past(i_vm_entry, 2))
      else $error("halted without a halt event");
   AST_ACT_SHUT: assert property ($past(i_ce) && $past(i_ce, 2) && o_activity == ACT_SHUTDOWN
      && $past(o_activity) != ACT_SHUTDOWN
      |-> $past(i_serious_error, 2) || $past(i_exception, 2) || $past(i_vm_entry, 2))
      else $error("shutdown without a fault");
   AST_ACT_WAIT: assert property ($past(i_ce) && $past(i_ce, 2) && o_activity == ACT_WAIT_SIP
      && $past(o_activity) != ACT_WAIT_SIP |-> $past(i_wait_startup, 2) || $past(i_vm_entry, 2))
      else $error("startup wait without cause");
   AST_ACT_RANGE: assert property (o_activity[31:2] == 30'h0)
      else $error("activity outside defined states");
   AST_INTR_RSVD: assert property (o_interruptibility[31:4] == 28'h0)
      else $error("interruptibility reserved bits set");
   AST_ENTRY_FAIL: assert property (o_entry_fail |-> $past(i_vm_entry) && $past(i_ce))
      else $error("entry fail without entry");
   // ----------------------------------------------------------------
   // Blocking and debug flags
   // ----------------------------------------------------------------
   AST_SIF: assert property (i_ce && i_set_interrupt_flag_instruction && !i_interrupt_flag && !i_vm_entry
      ##1 i_ce |=> o_interruptibility[BIT_BLK_SIF])
      else $error("interrupt flag blocking missing");
   AST_SMI: assert property (i_ce && i_system_management_interrupt && !i_rsm && !i_vm_entry
      ##1 i_ce |=> o_interruptibility[BIT_BLK_SMI])
      else $error("management interrupt blocking missing");
   AST_PDBG: assert property (i_ce && (|i_breakpoint_hit_flags) && !i_vm_entry && !i_debug_delivered
      ##1 i_ce |=> (o_pending_debug[3:0] & $past(i_breakpoint_hit_flags, 2)) == $past(i_breakpoint_hit_flags, 2))
      else $error("breakpoint hit not recorded");
   AST_RDATA_IDLE: assert property ($past(i_ce) && !$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   COV_HALT: cover property (o_activity == ACT_HALTED);
   COV_FAIL: cover property (o_entry_fail);
   COV_IRQ: cover property ($rose(o_irq));
endmodule : guest_state_sva

bind guest_activity_event_blocking_state guest_state_sva i_guest_state_sva (.i_clk, .i_rst_b, .i_ce, .i_rd,
   .i_vm_entry, .i_halt_instruction, .i_wait_startup, .i_serious_error, .i_exception,
   .i_set_interrupt_flag_instruction, .i_interrupt_flag, .i_system_management_interrupt, .i_rsm,
   .i_breakpoint_hit_flags, .i_debug_delivered, .o_rdata, .o_activity, .o_interruptibility,
   .o_pending_debug, .o_entry_fail, .o_irq);

// File: verification/guest_activity_event_blocking_state_bench.sv
// Self-checking bench for the guest state block
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module guest_activity_event_blocking_state_bench;
   import guest_state_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        i_ce = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_interrupt_flag = 1'b1;
   logic [3:0]  bkpt = 4'h0;
   logic [19:0] ev = 20'h0;
   logic [31:0] o_rdata, o_activity, o_interruptibility;
   logic [63:0] o_pending_debug, got;
   logic        o_entry_fail, o_irq, look = 1'b0, due;
   logic [66:0] notes[$];
   logic [66:0] nt;
   logic [31:0] r;
   logic [3:0]  b;
   int          n_fail = 0;
   int          tests_run = 0;
   int          seed = 57;

   guest_activity_event_blocking_state i_guest_activity_event_blocking_state (
      .i_clk, .i_rst_b, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .i_vm_exit(ev[0]), .i_vm_entry(ev[1]), .i_halt_instruction(ev[2]),
      .i_startup_interprocessor_interrupt(ev[3]), .i_wait_startup(ev[4]), .i_serious_error(ev[5]),
      .i_exception(ev[6]), .i_monitor_wait_instruction(ev[7]), .i_set_interrupt_flag_instruction(ev[8]),
      .i_interrupt_flag, .i_stack_segment_load(ev[9]), .i_instruction_retired(ev[10]),
      .i_system_management_interrupt(ev[11]), .i_rsm(ev[12]), .i_nmi_delivered(ev[13]),
      .i_interrupt_return_instruction(ev[14]), .i_double_fault_start(ev[15]), .i_double_fault_done(ev[16]),
      .i_breakpoint_hit_flags(bkpt), .i_enabled_breakpoint(ev[17]), .i_single_step(ev[18]),
      .i_debug_delivered(ev[19]), .o_activity, .o_interruptibility, .o_pending_debug, .o_entry_fail, .o_irq);

   always #5 i_clk = ~i_clk;
   // ----------------------------------------------------------------
   // Drivers: rd, see and hit note their expectation before acting; wr and pulse note none
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      notes.push_back({3'h0, 32'h0, e});
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask : rd
   task automatic see(input logic [2:0] s, input logic [63:0] e);
      notes.push_back({s, e});
      @(posedge i_clk);
      look <= 1'b1;
      @(posedge i_clk);
      look <= 1'b0;
   endtask : see
   task automatic pulse(input logic [19:0] m);
      @(posedge i_clk);
      ev <= m;
      @(posedge i_clk);
      ev <= 20'h0;
   endtask : pulse
   // Pulses an event and samples the outputs launched by that same edge
   task automatic hit(input logic [19:0] m, input logic [2:0] s, input logic [63:0] e);
      notes.push_back({s, e});
      @(posedge i_clk);
      ev <= m;
      look <= 1'b1;
      @(posedge i_clk);
      ev <= 20'h0;
      look <= 1'b0;
   endtask : hit
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   function automatic logic [63:0] pick(input logic [2:0] s);
      case (s)
         3'h0: return 64'(o_rdata);
         3'h1: return 64'(o_activity);
         3'h2: return 64'(o_interruptibility);
         3'h3: return o_pending_debug;
         3'h4: return 64'(o_entry_fail);
         default: return 64'(o_irq);
      endcase
   endfunction : pick
   // ----------------------------------------------------------------
   // Monitor: a read answers one cycle on, a look samples settled outputs
   // ----------------------------------------------------------------
   always @(posedge i_clk)
   begin
      due = i_rd | look;
      #1;
      if (due)
      begin
         nt = notes.pop_front();
         got = pick(nt[66:64]);
         `CHK(got, nt[63:0])
      end
   end
   initial
   begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_b <= 1'b1;
      i_ce <= 1'b1;
      see(3'h1, 64'h0);
      see(3'h2, 64'h0);
      see(3'h3, 64'h0);
      rd(ADDR_ACTIVITY, RST_ACTIVITY);
      rd(ADDR_PDBG_HI, 32'h0);
      rd(ADDR_CAPS, CAPS_VALUE);
      rd(8'hFC, 32'h0);
      pulse(20'h0_0080);
      see(3'h1, ACT_RUNNING);
      pulse(20'h0_0004);
      see(3'h1, ACT_HALTED);
      pulse(20'h0_0010);
      see(3'h1, ACT_WAIT_SIP);
      pulse(20'h0_0008);
      see(3'h1, ACT_RUNNING);
      wr(ADDR_IRQ_MASK, 32'h2);
      pulse(20'h0_8000);
      pulse(20'h1_0000);
      pulse(20'h0_0040);
      see(3'h1, ACT_RUNNING);
      pulse(20'h0_8000);
      pulse(20'h0_0040);
      see(3'h1, ACT_SHUTDOWN);
      see(3'h5, 64'h1);
      rd(ADDR_IRQ_STATUS, 32'h2);
      see(3'h5, 64'h0);
      wr(ADDR_INTR_STATE, 32'h10);
      hit(20'h0_0002, 3'h4, 64'h1);
      see(3'h1, ACT_SHUTDOWN);
      see(3'h5, 64'h0);
      rd(ADDR_IRQ_STATUS, 32'h1);
      r = $random(seed);
      wr(ADDR_INTR_STATE, 32'hF);
      wr(ADDR_ACTIVITY, ACT_HALTED);
      wr(ADDR_PDBG_LO, r);
      rd(ADDR_PDBG_LO, r);
      hit(20'h0_0002, 3'h4, 64'h0);
      see(3'h1, ACT_HALTED);
      see(3'h2, 64'hF);
      see(3'h3, {32'h0, r});
      pulse(20'h0_4000);
      see(3'h2, 64'h7);
      pulse(20'h0_0400);
      see(3'h2, 64'h4);
      pulse(20'h0_1000);
      see(3'h2, 64'h0);
      i_interrupt_flag <= 1'b0;
      pulse(20'h0_0200);
      see(3'h2, 64'h2);
      pulse(20'h0_0800);
      see(3'h2, 64'hE);
      pulse(20'h0_5400);
      see(3'h2, 64'h0);
      wr(ADDR_CTRL, 32'h1);
      pulse(20'h0_2000);
      see(3'h2, 64'h0);
      wr(ADDR_CTRL, 32'h0);
      pulse(20'h0_2000);
      see(3'h2, 64'h8);
      pulse(20'h8_0000);
      see(3'h3, 64'h0);
      b = 4'($random(seed)) | 4'h1;
      bkpt <= b;
      pulse(20'h6_0000);
      bkpt <= 4'h0;
      see(3'h3, {48'h0, 16'h5000 | 16'(b)});
      pulse(20'h0_0100);
      pulse(20'h0_0001);
      rd(ADDR_ACTIVITY, ACT_HALTED);
      rd(ADDR_INTR_STATE, 32'h9);
      rd(ADDR_PDBG_LO, 32'h5000 | 32'(b));
      i_ce <= 1'b0;
      pulse(20'h8_0000);
      i_ce <= 1'b1;
      see(3'h3, {48'h0, 16'h5000 | 16'(b)});
      pulse(20'h0_0020);
      see(3'h1, ACT_SHUTDOWN);
      tally_and_finish();
   end
endmodule : guest_activity_event_blocking_state_bench
